// ---- rtl/ssd_pkg.sv ----
// Constants, frame layout and carrier types for the serial slave decoder.
// Assumes a byte-level UART outside that delivers received bytes and takes bytes to send.
package ssd_pkg;
    // ------------------------------------------------------------
    // Frame constants
    // ------------------------------------------------------------
    localparam logic [7:0]  SSD_ADDR_BCAST   = 8'h00;
    localparam logic [7:0]  SSD_ADDR_MIN     = 8'h01;
    localparam logic [7:0]  SSD_ADDR_MAX     = 8'h10;
    localparam logic [7:0]  SSD_FC_READ      = 8'h03;
    localparam logic [7:0]  SSD_FC_COIL      = 8'h05;
    localparam logic [7:0]  SSD_RD_BYTECNT   = 8'h02;
    localparam logic [15:0] SSD_REG_JUDGE    = 16'h9025;
    localparam logic [15:0] SSD_RD_COUNT     = 16'h0001;
    localparam logic [15:0] SSD_COIL_ON      = 16'hFF00;
    localparam logic [15:0] SSD_COIL_OFF     = 16'h0000;
    localparam logic [15:0] SSD_CRC_INIT     = 16'hFFFF;
    localparam logic [15:0] SSD_CRC_POLY     = 16'hA001;
    localparam logic [3:0]  SSD_QUERY_LEN    = 4'h8;
    localparam logic [3:0]  SSD_READ_RSP_LEN = 4'h7;

    // ------------------------------------------------------------
    // Coil addresses and coil indices in ssd_coils_s member order (safety, the first member, is bit 5 of the vector)
    // ------------------------------------------------------------
    localparam logic [15:0] SSD_COIL_SAFETY  = 16'h0401;
    localparam logic [15:0] SSD_COIL_SERVO   = 16'h0403;
    localparam logic [15:0] SSD_COIL_FAULT   = 16'h0407;
    localparam logic [15:0] SSD_COIL_TMODE   = 16'h0414;
    localparam logic [15:0] SSD_COIL_CAPT    = 16'h0415;
    localparam logic [15:0] SSD_COIL_JOGP    = 16'h0416;
    localparam int          SSD_BIT_SAFETY   = 0;
    localparam int          SSD_BIT_SERVO    = 1;
    localparam int          SSD_BIT_FAULT    = 2;
    localparam int          SSD_BIT_TMODE    = 3;
    localparam int          SSD_BIT_CAPT     = 4;
    localparam int          SSD_BIT_JOGP     = 5;
    localparam int          SSD_NUM_COILS    = 6;
    localparam logic [5:0]  SSD_COILS_RESET  = 6'h00;

    // ------------------------------------------------------------
    // Timing: silent interval of 3.5 characters at the link rate
    // ------------------------------------------------------------
    localparam int          SSD_CLK_MHZ      = 100;
    localparam int          SSD_SILENCE_US   = 4010;
    localparam int          SSD_SILENCE_CYC  = SSD_SILENCE_US * SSD_CLK_MHZ;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } ssd_byte_s;

    typedef struct packed {
        logic safety_speed_limit_coil;
        logic servo_enable_coil;
        logic fault_clear_coil;
        logic teach_mode_coil;
        logic position_capture_coil;
        logic jog_positive_coil;
    } ssd_coils_s;
endpackage

// ---- rtl/ssd_crc16.sv ----
// Byte-wide CRC-16 step used for both received and transmitted frames.
// Assumes the caller clears it at frame start and feeds one byte per strobe.
`timescale 1ns/1ps
module ssd_crc16
    import ssd_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        clear,
    input  wire logic        step,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc
);
    // ------------------------------------------------------------
    // Eight bit-serial shifts folded into one cycle
    // ------------------------------------------------------------
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ SSD_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // Clear wins so a new frame never inherits a stale remainder
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            crc <= SSD_CRC_INIT;
        end else if (clear) begin
            crc <= SSD_CRC_INIT;
        end else if (step) begin
            crc <= crc_byte(crc, data);
        end
    end
endmodule

// ---- rtl/ssd_slave.sv ----
// Slave command interpreter: judgement status read and single-coil writes.
// Assumes a byte UART outside; rx bytes arrive as one-cycle strobes, tx takes
// a byte on tx_valid && tx_ready. The line-idle pin is asynchronous.
`timescale 1ns/1ps

module ssd_slave
    import ssd_pkg::*;
#(
    parameter int SILENCE_CYC = SSD_SILENCE_CYC
)(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [3:0]  axis_number,
    input  wire logic        line_idle,
    input  wire ssd_byte_s   rx_byte,
    input  wire logic [15:0] judgement_status,
    input  wire logic        tx_ready,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    output ssd_coils_s       coils,
    output logic             coil_write_pulse
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SSD_RX   = 2'b00,
        SSD_WAIT = 2'b01,
        SSD_TX   = 2'b10,
        SSD_POST = 2'b11
    } ssd_state_e;

    localparam int CW = $clog2(SILENCE_CYC + 1);

    ssd_state_e      state_q;
    logic [7:0]      frame_q [0:7];
    logic [3:0]      rx_cnt_q;
    logic [3:0]      tx_idx_q;
    logic [3:0]      tx_len_q;
    logic [CW-1:0]   quiet_q;
    logic            quiet_done;
    logic [2:0]      idle_sync_q;
    logic            idle_stable_q;
    logic [15:0]     rx_crc;
    logic [15:0]     tx_crc;
    logic [7:0]      own_addr;
    logic [15:0]     f_addr;
    logic [15:0]     f_data;
    logic            frame_end;
    logic            crc_ok;
    logic            is_own;
    logic            is_bcast;
    logic            read_ok;
    logic            coil_known;
    logic            coil_data_ok;
    logic            coil_ok;
    logic            tx_fire;
    logic [7:0]      tx_byte;
    logic            tx_body;
    logic [15:0]     tx_crc_next;

    // ------------------------------------------------------------
    // Line-idle synchroniser; change taken when stages two and three agree
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            idle_sync_q   <= 3'h0;
            idle_stable_q <= 1'b0;
        end else begin
            idle_sync_q <= {idle_sync_q[1:0], line_idle};
            if (idle_sync_q[1] == idle_sync_q[2]) begin
                idle_stable_q <= idle_sync_q[2];
            end
        end
    end

    // Silence counter: runs while the line is idle, restarts on any rx byte
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            quiet_q <= '0;
        end else if (rx_byte.valid || !idle_stable_q || tx_fire) begin
            quiet_q <= '0;
        end else if (!quiet_done) begin
            quiet_q <= quiet_q + CW'(1);
        end
    end
    assign quiet_done = (quiet_q == CW'(SILENCE_CYC));

    // ------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------
    assign own_addr     = {4'h0, axis_number} + 8'h01;
    assign f_addr       = {frame_q[2], frame_q[3]};
    assign f_data       = {frame_q[4], frame_q[5]};
    // A full eight bytes followed by silence closes a query
    assign frame_end    = (state_q == SSD_RX) && quiet_done && (rx_cnt_q == SSD_QUERY_LEN);
    // Remainder over data plus transmitted CRC is zero for a clean frame
    assign crc_ok       = (rx_crc == 16'h0000);
    assign is_own       = (frame_q[0] == own_addr);
    assign is_bcast     = (frame_q[0] == SSD_ADDR_BCAST);
    assign read_ok      = is_own && (frame_q[1] == SSD_FC_READ) &&
                          (f_addr == SSD_REG_JUDGE) && (f_data == SSD_RD_COUNT);
    assign coil_known   = (f_addr == SSD_COIL_SAFETY) || (f_addr == SSD_COIL_SERVO) ||
                          (f_addr == SSD_COIL_FAULT)  || (f_addr == SSD_COIL_TMODE) ||
                          (f_addr == SSD_COIL_CAPT)   || (f_addr == SSD_COIL_JOGP);
    assign coil_data_ok = (f_data == SSD_COIL_ON) || (f_data == SSD_COIL_OFF);
    // Invalid coil address or data is simply not answered
    assign coil_ok      = (is_own || is_bcast) && (frame_q[1] == SSD_FC_COIL) &&
                          coil_known && coil_data_ok;

    // Receive buffer; bytes past eight are counted but not stored
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_cnt_q <= 4'h0;
        end else if (state_q != SSD_RX) begin
            rx_cnt_q <= 4'h0;
        end else if (quiet_done && !rx_byte.valid) begin
            rx_cnt_q <= 4'h0;
        end else if (rx_byte.valid && rx_cnt_q != 4'hF) begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (state_q == SSD_RX && rx_byte.valid && rx_cnt_q < SSD_QUERY_LEN) begin
            frame_q[rx_cnt_q[2:0]] <= rx_byte.data;
        end
    end

    ssd_crc16 u_rx_crc (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .clear   (state_q != SSD_RX || (quiet_done && !rx_byte.valid)),
        .step    (state_q == SSD_RX && rx_byte.valid),
        .data    (rx_byte.data),
        .crc     (rx_crc)
    );

    // ------------------------------------------------------------
    // Coil outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            coils            <= SSD_COILS_RESET;
            coil_write_pulse <= 1'b0;
        end else begin
            coil_write_pulse <= 1'b0;
            if (frame_end && crc_ok && coil_ok) begin
                coil_write_pulse <= 1'b1;
                case (f_addr)
                    SSD_COIL_SAFETY: coils.safety_speed_limit_coil <= f_data[15];
                    SSD_COIL_SERVO:  coils.servo_enable_coil       <= f_data[15];
                    SSD_COIL_FAULT:  coils.fault_clear_coil        <= f_data[15];
                    SSD_COIL_TMODE:  coils.teach_mode_coil         <= f_data[15];
                    SSD_COIL_CAPT:   coils.position_capture_coil   <= f_data[15];
                    SSD_COIL_JOGP:   coils.jog_positive_coil       <= f_data[15];
                    default:         coils                         <= coils;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Reply sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q  <= SSD_RX;
            tx_len_q <= 4'h0;
        end else begin
            case (state_q)
                SSD_RX: begin
                    if (frame_end && crc_ok && read_ok) begin
                        state_q  <= SSD_WAIT;
                        tx_len_q <= SSD_READ_RSP_LEN;
                    end else if (frame_end && crc_ok && coil_ok && !is_bcast) begin
                        state_q  <= SSD_WAIT;
                        tx_len_q <= SSD_QUERY_LEN;
                    end
                end
                // Query already ended in silence; this is the gap before our reply
                SSD_WAIT: state_q <= SSD_TX;
                SSD_TX: begin
                    if (tx_fire && tx_idx_q == tx_len_q - 4'h1) begin
                        state_q <= SSD_POST;
                    end
                end
                // Hold off receiving until the trailing silence has elapsed
                SSD_POST: begin
                    if (quiet_done) begin
                        state_q <= SSD_RX;
                    end
                end
                default: state_q <= SSD_RX;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_idx_q <= 4'h0;
        end else if (state_q != SSD_TX) begin
            tx_idx_q <= 4'h0;
        end else if (tx_fire) begin
            tx_idx_q <= tx_idx_q + 4'h1;
        end
    end

    // Byte selection; status bytes come from the loaded flop so the check matches the wire
    assign tx_body = (tx_idx_q < tx_len_q - 4'h2);
    always_comb begin
        tx_byte = 8'h00;
        if (!tx_body) begin
            tx_byte = (tx_idx_q == tx_len_q - 4'h2) ? tx_crc[7:0] : tx_crc[15:8];
        end else if (tx_len_q == SSD_READ_RSP_LEN) begin
            case (tx_idx_q)
                4'h0:    tx_byte = own_addr;
                4'h1:    tx_byte = SSD_FC_READ;
                4'h2:    tx_byte = SSD_RD_BYTECNT;
                4'h3:    tx_byte = tx_data;
                default: tx_byte = tx_data;
            endcase
        end else begin
            tx_byte = frame_q[tx_idx_q[2:0]];
        end
    end

    assign tx_valid = (state_q == SSD_TX);
    assign tx_fire  = tx_valid && tx_ready;

    // Data output held in a flop; loaded with the first byte in SSD_WAIT, then updated only on an accepted byte
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_data <= 8'h00;
        end else if (state_q == SSD_WAIT) begin
            tx_data <= (tx_len_q == SSD_READ_RSP_LEN) ? own_addr : frame_q[0];
        end else if (tx_fire) begin
            tx_data <= tx_next_byte(tx_idx_q + 4'h1);
        end
    end

    // Next-byte lookahead repeats the selection for the next index, taking status bytes from judgement_status
    function automatic logic [7:0] tx_next_byte(input logic [3:0] idx);
        logic [7:0] b;
        b = 8'h00;
        if (idx == tx_len_q - 4'h2) begin
            b = tx_crc_next[7:0];
        end else if (idx == tx_len_q - 4'h1) begin
            b = tx_crc_next[15:8];
        end else if (tx_len_q == SSD_READ_RSP_LEN) begin
            case (idx)
                4'h1:    b = SSD_FC_READ;
                4'h2:    b = SSD_RD_BYTECNT;
                4'h3:    b = judgement_status[15:8];
                default: b = judgement_status[7:0];
            endcase
        end else begin
            b = frame_q[idx[2:0]];
        end
        return b;
    endfunction

    // CRC after the byte now leaving, so the trailer is ready in time
    always_comb begin
        tx_crc_next = tx_crc;
        if (tx_body) begin
            tx_crc_next = tx_crc ^ {8'h00, tx_byte};
            for (int i = 0; i < 8; i++) begin
                tx_crc_next = tx_crc_next[0] ? ((tx_crc_next >> 1) ^ SSD_CRC_POLY)
                                             : (tx_crc_next >> 1);
            end
        end
    end

    ssd_crc16 u_tx_crc (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .clear   (state_q != SSD_TX),
        .step    (tx_fire && tx_body),
        .data    (tx_byte),
        .crc     (tx_crc)
    );
endmodule

// ---- verification/ssd_tb_pkg.sv ----
// Frame check helper shared by the host model and the bench.
// Assumes frames are byte queues in transmit order.
package ssd_tb_pkg;
    // ------------------------------------------------------------
    // Reflected CRC-16, seed all ones
    // ------------------------------------------------------------
    function automatic logic [15:0] ssd_crc(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
            end
        end
        return c;
    endfunction
endpackage

// ---- verification/ssd_host_model.sv ----
// Host master model: frames six payload bytes plus check, takes reply bytes.
// Assumes the bench pulses go for one cycle and waits for busy to drop.
`timescale 1ns/1ps
module ssd_host_model
    import ssd_pkg::*;
    import ssd_tb_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        go,
    input  wire logic [47:0] pl,
    input  wire logic        bad_crc,
    input  wire logic        slow,
    output logic             busy,
    output logic             line_idle,
    output ssd_byte_s        rx_byte,
    output logic             tx_ready
);
    logic [7:0]  q[$];
    logic [15:0] c;

    initial begin
        busy = 1'b0;
        line_idle = 1'b1;
        rx_byte = '0;
        tx_ready = 1'b0;
    end

    // Slow mode stalls every other cycle, so held bytes get exercised
    always @(posedge clk_sys) begin
        tx_ready <= #1 (slow ? ~tx_ready : 1'b1);
    end

    // Eight-byte query, check low byte first, line held busy for the whole query
    always @(posedge clk_sys) begin
        if (go) begin
            #1 busy = 1'b1;
            q.delete();
            for (int i = 5; i >= 0; i--) q.push_back(pl[8*i +: 8]);
            c = ssd_crc(q) ^ {15'h0000, bad_crc};
            q.push_back(c[7:0]);
            q.push_back(c[15:8]);
            foreach (q[i]) begin
                line_idle = 1'b0;
                repeat (3) @(posedge clk_sys);
                #1 rx_byte = '{valid: 1'b1, data: q[i]};
                @(posedge clk_sys);
                // Released data never keeps the last value
                #1 rx_byte = '{valid: 1'b0, data: ~q[i]};
            end
            line_idle = 1'b1;
            busy = 1'b0;
        end
    end
endmodule

// ---- verification/ssd_slave_props.sv ----
// Checker for the slave decoder, seeing only its ports.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module ssd_slave_props
    import ssd_pkg::*;
#(
    parameter int SILENCE_CYC = SSD_SILENCE_CYC
)(
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic [3:0]  axis_number,
    input wire logic        line_idle,
    input wire ssd_byte_s   rx_byte,
    input wire logic [15:0] judgement_status,
    input wire logic        tx_ready,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire ssd_coils_s  coils,
    input wire logic        coil_write_pulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    logic [31:0] quiet_q;
    logic [3:0]  sent_q;

    // Cycles since the line last carried anything in either direction
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) quiet_q <= '0;
        else if (rx_byte.valid || tx_valid) quiet_q <= '0;
        else if (quiet_q != '1) quiet_q <= quiet_q + 32'h1;
    end

    // Bytes handed over in the current reply
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) sent_q <= '0;
        else if (tx_valid && tx_ready) sent_q <= sent_q + 4'h1;
        else if (!tx_valid) sent_q <= '0;
    end

    property p_pulse_single; coil_write_pulse |=> !coil_write_pulse; endproperty
    a_pulse_single: assert property (p_pulse_single) else $error("coil pulse too long");
    property p_coils_change; !$stable(coils) |-> coil_write_pulse; endproperty
    a_coils_change: assert property (p_coils_change) else $error("coil moved alone");
    property p_hold_valid; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
    a_hold_valid: assert property (p_hold_valid) else $error("reply byte dropped");
    property p_write_no_tx; coil_write_pulse |-> !tx_valid; endproperty
    a_write_no_tx: assert property (p_write_no_tx) else $error("reply overlaps write");
    property p_reply_quiet; $rose(tx_valid) |-> quiet_q >= SILENCE_CYC; endproperty
    a_reply_quiet: assert property (p_reply_quiet) else $error("reply without silence");
    property p_write_quiet; coil_write_pulse |-> quiet_q >= SILENCE_CYC - 1; endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("write before silence");
    property p_reply_len; $fell(tx_valid) |-> sent_q == 4'h7 || sent_q == 4'h8; endproperty
    a_reply_len: assert property (p_reply_len) else $error("reply length wrong");
    property p_first_addr; $rose(tx_valid) |-> tx_data == 8'(axis_number) + 8'h01; endproperty
    a_first_addr: assert property (p_first_addr) else $error("reply address wrong");
    property p_second_fc;
        tx_valid && sent_q == 4'h1 |-> tx_data == SSD_FC_READ || tx_data == SSD_FC_COIL;
    endproperty
    a_second_fc: assert property (p_second_fc) else $error("reply function wrong");

    c_write: cover property (coil_write_pulse);
    c_stall: cover property (tx_valid && !tx_ready);
    c_read: cover property ($fell(tx_valid) && sent_q == 4'h7);
    c_echo: cover property ($fell(tx_valid) && sent_q == 4'h8);
endmodule

bind ssd_slave ssd_slave_props #(.SILENCE_CYC(SILENCE_CYC)) props_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .axis_number(axis_number), .line_idle(line_idle),
    .rx_byte(rx_byte), .judgement_status(judgement_status), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .coils(coils), .coil_write_pulse(coil_write_pulse)
);

// ---- verification/test_serial_slave_status_and_coil_decode.sv ----
// Bench for the slave decoder: table of queries, then awkward cases.
// Assumes the host model and the bound checker; short silence for speed.
`timescale 1ns/1ps
module test_serial_slave_status_and_coil_decode;
    import ssd_pkg::*;
    import ssd_tb_pkg::*;
    localparam int SIL = 20;
    typedef struct packed {
        logic [47:0] pl;
        logic [3:0]  rlen;
        logic [5:0]  cl;
        logic        pw;
    } ssd_row_s;
    // Coil bits: safety, servo, fault, teach, capture, jog
    localparam ssd_row_s ROWS [16] = '{
        '{48'h040504_01FF00, 4'h8, 6'h20, 1'b1}, '{48'h040504_03FF00, 4'h8, 6'h30, 1'b1},
        '{48'h040504_07FF00, 4'h8, 6'h38, 1'b1}, '{48'h000504_14FF00, 4'h0, 6'h3C, 1'b1},
        '{48'h040504_15FF00, 4'h8, 6'h3E, 1'b1}, '{48'h040504_16FF00, 4'h8, 6'h3F, 1'b1},
        '{48'h040504_010000, 4'h8, 6'h1F, 1'b1}, '{48'h040504_031234, 4'h0, 6'h1F, 1'b0},
        '{48'h040504_08FF00, 4'h0, 6'h1F, 1'b0}, '{48'h050504_070000, 4'h0, 6'h1F, 1'b0},
        '{48'h040390_250001, 4'h7, 6'h1F, 1'b0}, '{48'h040390_240001, 4'h0, 6'h1F, 1'b0},
        '{48'h040390_250002, 4'h0, 6'h1F, 1'b0}, '{48'h040604_01FF00, 4'h0, 6'h1F, 1'b0},
        '{48'h000504_070000, 4'h0, 6'h17, 1'b1}, '{48'h000390_250001, 4'h0, 6'h17, 1'b0}
    };

    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  axis_number = 4'h3;
    logic [15:0] judgement_status = 16'h0105;
    logic        go = 1'b0;
    logic [47:0] pl = '0;
    logic        bad_crc = 1'b0;
    logic        slow = 1'b0;
    logic        busy, line_idle, tx_ready, tx_valid, coil_write_pulse;
    logic [7:0]  tx_data;
    ssd_byte_s   rx_byte;
    ssd_coils_s  coils;
    logic [7:0]  rsp[$];
    int          n_fail = 0;
    int          comparisons = 0;
    int          n_pulse = 0;
    int          cyc = 0;
    logic [7:0]  ref_q[$];

    always #5 clk_sys = ~clk_sys;

    ssd_slave #(.SILENCE_CYC(SIL)) dut_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .axis_number(axis_number), .line_idle(line_idle),
        .rx_byte(rx_byte), .judgement_status(judgement_status), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .coils(coils), .coil_write_pulse(coil_write_pulse)
    );
    ssd_host_model host_u (
        .clk_sys(clk_sys), .go(go), .pl(pl), .bad_crc(bad_crc), .slow(slow), .busy(busy),
        .line_idle(line_idle), .rx_byte(rx_byte), .tx_ready(tx_ready)
    );

    task automatic conclude();
        if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Reply capture, pulse count and hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (tx_valid && tx_ready) rsp.push_back(tx_data);
        if (coil_write_pulse) n_pulse++;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end

    // One query, then wait out reply plus silence; bounded by busy count
    task automatic run(input ssd_row_s r, input int wt);
        logic [7:0]  e[$];
        logic [15:0] c;
        int          n0;
        int          k;
        n0 = n_pulse;
        k = 0;
        rsp.delete();
        pl = r.pl;
        go = 1'b1;
        @(posedge clk_sys);
        #1 go = 1'b0;
        @(posedge clk_sys);
        while (busy && k < 200) begin
            @(posedge clk_sys);
            k++;
        end
        repeat (wt) @(posedge clk_sys);
        #1;
        for (int i = 5; i >= 0; i--) e.push_back(r.pl[8*i +: 8]);
        if (r.rlen == 4'h7) e = '{e[0], 8'h03, 8'h02, judgement_status[15:8], judgement_status[7:0]};
        c = ssd_crc(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        chk("reply_len", 16'(rsp.size()), {12'h000, r.rlen});
        if (r.rlen != 4'h0) foreach (e[i]) chk("reply_byte", {8'h00, rsp[i]}, {8'h00, e[i]});
        chk("coils", {10'h000, coils}, {10'h000, r.cl});
        chk("pulses", 16'(n_pulse - n0), {15'h0000, r.pw});
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        chk("reset_out", {tx_valid, coil_write_pulse, coils, tx_data}, 16'h0000);
        // Check routine against a known good query trailer
        ref_q = '{8'h01, 8'h03, 8'h90, 8'h25, 8'h00, 8'h01};
        chk("crc_ref", ssd_crc(ref_q), 16'hC1B8);
        // Let the silence counter fill before the first query
        repeat (SIL + 5) @(posedge clk_sys);
        #1;
        foreach (ROWS[i]) run(ROWS[i], SIL + 60);
        // Corrupted check on a write that would otherwise set safety
        bad_crc = 1'b1;
        run('{48'h040504_01FF00, 4'h0, 6'h17, 1'b0}, SIL + 60);
        bad_crc = 1'b0;
        // Stalling host and a fresh status word
        slow = 1'b1;
        judgement_status = 16'hA55A;
        run('{48'h040390_250001, 4'h7, 6'h17, 1'b0}, SIL + 100);
        slow = 1'b0;
        // Highest axis answers at 10, nobody at 11
        axis_number = 4'hF;
        run('{48'h100390_250001, 4'h7, 6'h17, 1'b0}, SIL + 60);
        run('{48'h110390_250001, 4'h0, 6'h17, 1'b0}, SIL + 60);
        // Reset in mid-run clears every coil; replies still work after it
        rst_b = 1'b0;
        @(posedge clk_sys);
        #1 rst_b = 1'b1;
        chk("reset_mid", {tx_valid, coil_write_pulse, coils, tx_data}, 16'h0000);
        repeat (SIL + 5) @(posedge clk_sys);
        #1;
        run('{48'h100390_250001, 4'h7, 6'h00, 1'b0}, SIL + 60);
        conclude();
    end
endmodule
